// ### miv_pkg.sv
// miv_pkg: constants, types and vector layout for the maskable interrupt vectoring block
// assumes a single clock domain; all control bits arrive as plain ports from the core side
// Notes on behaviour
// R1 - uart1 tx/nack vector 19, rx/ack 20
// R2 - timer a0..a4 vectors 21..25 from 0x54
// R3 - timer b0..b2 vectors 26..28 from 0x68
// R4 - external lines 0..2 vectors 29..31 from 0x74
// R5 - vectors 32..63 reserved for software interrupts
// R6 - global enable never blocks software interrupts
// R7 - vector offsets are relative to base register
// R8 - select bits 7/6 route shared collision slots
// R9 - software sets select b bit7 for line5
// R10 - select b bit6 picks serial3 or line4
// R11 - software clears select a bit2 for can
// R12 - select a bit1 picks adc or key
// R13 - i2c mode uses nack/ack as tx/rx source
// R14 - collision slot: home-bus collision or i2c start/stop
// R15 - gating by enable, threshold and level field
// R16 - pending flag set on source request
// R17 - writing 0 clears pending; 1 ignored
// R18 - software edits control only when source idle
// R19 - software zeroes level of lines 3..5 narrow bus
// R20 - both-edge selection needs falling polarity
// R21 - serial3 slot keeps polarity at zero
// R22 - accept when enabled, pending, level above threshold
// R23 - level 000 disables, 001..111 rising priority
// R24 - pending cleared when request accepted
// R25 - threshold 111 blocks every maskable source
// R26 - fetch address equals base plus four times vector
package miv_pkg;
   localparam int          MIV_NSRC      = 32;
   localparam int          MIV_NW        = 6;
   localparam int          MIV_AW        = 20;
   localparam logic [2:0]  MIV_LVL_OFF   = 3'h0;
   localparam logic [2:0]  MIV_IPL_BLOCK = 3'h7;
   localparam logic [5:0]  MIV_SW_FIRST  = 6'h20;
   localparam logic [11:0] MIV_OFS_UART1_TX = 12'h04c;
   localparam logic [11:0] MIV_OFS_TA0    = 12'h054;
   localparam logic [11:0] MIV_OFS_TB0    = 12'h068;
   localparam logic [11:0] MIV_OFS_LINE0  = 12'h074;
   localparam logic [11:0] MIV_OFS_SW     = 12'h080;
   // vector numbers of sources in the table
   localparam logic [4:0]  MIV_V_B4_COL  = 5'h06;
   localparam logic [4:0]  MIV_V_B3_COL  = 5'h07;
   localparam logic [4:0]  MIV_V_LINE5   = 5'h08;
   localparam logic [4:0]  MIV_V_S3_L4   = 5'h09;
   localparam logic [4:0]  MIV_V_ADC_KEY = 5'h0e;
   localparam logic [4:0]  MIV_V_UART1_TX = 5'h13;
   localparam logic [4:0]  MIV_V_UART1_RX = 5'h14;
   localparam logic [4:0]  MIV_V_TA0     = 5'h15;
   localparam logic [4:0]  MIV_V_TB0     = 5'h1a;
   localparam logic [4:0]  MIV_V_LINE0   = 5'h1d;
   // select register bit positions
   localparam int MIV_SA_SERIAL3 = 0;
   localparam int MIV_SA_ADC_KEY = 1;
   localparam int MIV_SA_CAN     = 2;
   localparam int MIV_SA_B3      = 6;
   localparam int MIV_SA_B4      = 7;
   localparam int MIV_SB_S3_L4   = 6;
   localparam int MIV_SB_LINE5   = 7;

   typedef struct packed {
      logic [2:0] level;
      logic       edge_sense;
   } miv_ctrl_t;

   typedef struct packed {
      logic [5:0]  vector;
      logic [2:0]  level;
      logic [19:0] address;
   } miv_grant_t;

   typedef struct packed {
      logic uart1_tx;
      logic uart1_nack;
      logic uart1_rx;
      logic uart1_ack;
      logic uart1_i2c;
      logic uart1_home_bus;
      logic uart1_collision;
      logic uart1_startstop;
      logic uart0_i2c;
      logic uart0_home_bus;
      logic uart0_collision;
      logic uart0_startstop;
      logic timer_b3;
      logic timer_b4;
      logic serial3;
      logic line4;
      logic line5;
      logic adc_done;
      logic key_in;
   } miv_src_t;
endpackage : miv_pkg

// ### miv_pending.sv
// miv_pending: one pending flag per slot
// assumes requests are single-cycle pulses synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module miv_pending
   import miv_pkg::*;
#(
   parameter int N = MIV_NSRC
)(
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [N-1:0] set_req,
   input  wire logic [N-1:0] sw_clear,
   input  wire logic [N-1:0] ack_clear,
   output var  logic [N-1:0] pend_r
);
   logic [N-1:0] pend_nxt;
   // a request in the clearing cycle survives: set beats clear
   assign pend_nxt = set_req | (pend_r & ~sw_clear & ~ack_clear); // R16 R17 R24
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         pend_r <= '0;
      else
         pend_r <= pend_nxt;
   end
endmodule : miv_pending
`default_nettype wire

// ### miv_top.sv
// miv_top: routes sources onto vector slots, gates them and presents one grant to the core
// assumes the core pulses accept when it branches to the presented vector
`timescale 1ns/1ps
`default_nettype none
module miv_top
   import miv_pkg::*;
#(
   parameter int N = MIV_NSRC
)(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [MIV_AW-1:0] vector_base_register,
   input  wire logic [7:0]        source_select_reg_a,
   input  wire logic [7:0]        source_select_reg_b,
   input  wire logic              global_enable,
   input  wire logic [2:0]        cpu_priority_threshold,
   input  wire miv_ctrl_t [N-1:0] ctrl,
   input  wire logic [N-1:0]      periph_req,
   input  wire miv_src_t          src,
   input  wire logic [N-1:0]      pend_write_zero,
   input  wire logic              sw_int,
   input  wire logic [5:0]        sw_vector,
   input  wire logic              accept,
   output logic                   irq_r,
   output miv_grant_t             grant_r,
   output logic                   sw_valid_r,
   output logic [MIV_AW-1:0]      sw_address_r,
   output logic [N-1:0]           request_pending_flag
);
   wire logic select_b4_or_uart1_collision = source_select_reg_a[MIV_SA_B4];
   wire logic select_b3_or_uart0_collision = source_select_reg_a[MIV_SA_B3];
   wire logic adc_or_key_select            = source_select_reg_a[MIV_SA_ADC_KEY];
   wire logic serial3_slot_enable          = source_select_reg_a[MIV_SA_SERIAL3];
   wire logic select_serial3_or_line4      = source_select_reg_b[MIV_SB_S3_L4];
   wire logic select_line5_slot            = source_select_reg_b[MIV_SB_LINE5];

   // fetch address relative to the base register, four bytes per slot
   function automatic logic [MIV_AW-1:0] vec_addr(input logic [MIV_AW-1:0] base,
                                                  input logic [5:0] num);
      vec_addr = base + {{(MIV_AW-8){1'b0}}, num, 2'b00}; // R7 R26
   endfunction : vec_addr

   // collision slot event, chosen by serial mode
   function automatic logic coll_evt(input logic i2c, input logic hb,
                                     input logic col, input logic ss);
      coll_evt = i2c ? ss : (hb & col); // R14
   endfunction : coll_evt

   wire logic uart1_tx_evt = src.uart1_i2c ? src.uart1_nack : src.uart1_tx; // R13 R1
   wire logic uart1_rx_evt = src.uart1_i2c ? src.uart1_ack : src.uart1_rx; // R13 R1
   wire logic u1_col = coll_evt(src.uart1_i2c, src.uart1_home_bus,
                                src.uart1_collision, src.uart1_startstop);
   wire logic u0_col = coll_evt(src.uart0_i2c, src.uart0_home_bus,
                                src.uart0_collision, src.uart0_startstop);
   wire logic slot_b4 = select_b4_or_uart1_collision ? u1_col : src.timer_b4; // R8
   wire logic slot_b3 = select_b3_or_uart0_collision ? u0_col : src.timer_b3; // R8
   // line5 shares its slot only when software selects it
   wire logic slot_l5 = select_line5_slot & src.line5; // R9
   // serial3 needs its slot enable as well as the selection
   wire logic slot_s3 = select_serial3_or_line4 ? src.line4
                                                : (serial3_slot_enable & src.serial3); // R10
   wire logic slot_ak = adc_or_key_select ? src.key_in : src.adc_done; // R12

   logic [N-1:0] req_vec;
   always_comb
   begin
      req_vec = periph_req;
      req_vec[MIV_V_B4_COL]   = slot_b4;
      req_vec[MIV_V_B3_COL]   = slot_b3;
      req_vec[MIV_V_LINE5]    = slot_l5;
      req_vec[MIV_V_S3_L4]    = slot_s3;
      req_vec[MIV_V_ADC_KEY]  = slot_ak;
      req_vec[MIV_V_UART1_TX] = uart1_tx_evt; // R1
      req_vec[MIV_V_UART1_RX] = uart1_rx_evt; // R1
   end

   logic [N-1:0] ack_vec;
   logic [N-1:0] pend;

   miv_pending #(.N(N)) u_pend (
      .clk       (clk),
      .rst       (rst),
      .set_req   (req_vec),
      .sw_clear  (pend_write_zero),
      .ack_clear (ack_vec),
      .pend_r    (pend)
   );

   // eligible sources: pending, level nonzero and above threshold
   logic [N-1:0] elig;
   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_elig
         assign elig[g] = pend[g] && (ctrl[g].level != MIV_LVL_OFF)
                          && (ctrl[g].level > cpu_priority_threshold); // R22 R23 R15
      end
   endgenerate

   // highest level wins; among equals the lower vector number
   // balanced comparison tree: depth grows with log2 of the slot count, not with the count
   // heap layout: node k has children 2k+1 (lower vectors) and 2k+2; N must be a power of two
   localparam int NODES = 2 * N - 1;
   wire logic [NODES-1:0] node_ok;
   wire logic [2:0]       node_lvl [NODES];
   wire logic [4:0]       node_idx [NODES];
   generate
      for (g = 0; g < N; g++)
      begin : g_leaf
         assign node_ok[N-1+g]  = elig[g];
         assign node_lvl[N-1+g] = ctrl[g].level;
         assign node_idx[N-1+g] = 5'(g);
      end
      for (g = 0; g < N - 1; g++)
      begin : g_node
         // the upper half wins only on a strictly higher level, so ties go to the lower vector
         wire logic upper_wins = node_ok[2*g+2]
                                 && (!node_ok[2*g+1] || node_lvl[2*g+2] > node_lvl[2*g+1]);
         assign node_ok[g]  = node_ok[2*g+1] | node_ok[2*g+2];
         assign node_lvl[g] = upper_wins ? node_lvl[2*g+2] : node_lvl[2*g+1];
         assign node_idx[g] = upper_wins ? node_idx[2*g+2] : node_idx[2*g+1];
      end
   endgenerate

   wire logic       any_elig = node_ok[0];
   wire logic [2:0] best_lvl = any_elig ? node_lvl[0] : MIV_LVL_OFF;
   wire logic [4:0] best_idx = any_elig ? node_idx[0] : 5'h00;

   // threshold 111 blocks all maskables since no level exceeds it; enable gates maskables only
   wire logic ipl_open   = cpu_priority_threshold != MIV_IPL_BLOCK; // R25
   wire logic irq_nxt    = global_enable & ipl_open & any_elig; // R15 R22
   wire logic take       = irq_r & accept;
   wire logic [5:0] gvec = {1'b0, grant_r.vector[4:0]};

   // accept clears only the presented slot
   always_comb
   begin
      ack_vec = '0;
      if (take)
         ack_vec[grant_r.vector[4:0]] = 1'b1; // R24
   end

   miv_grant_t grant_nxt;
   always_comb
   begin
      grant_nxt.vector  = {1'b0, best_idx};
      grant_nxt.level   = best_lvl;
      grant_nxt.address = vec_addr(vector_base_register, {1'b0, best_idx}); // R2 R3 R4
   end

   // software interrupts bypass enable and level gating
   wire logic sw_ok = sw_int & (sw_vector >= MIV_SW_FIRST); // R5 R6
   wire logic [MIV_AW-1:0] sw_addr_nxt = vec_addr(vector_base_register, sw_vector);

   // drop the request the cycle after acceptance so a stale grant is not retaken
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         irq_r <= 1'b0;
      else
         irq_r <= irq_nxt & ~take;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         grant_r <= '0;
      else
         grant_r <= grant_nxt;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sw_valid_r <= 1'b0;
      else
         sw_valid_r <= sw_ok; // R6
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         sw_address_r <= '0;
      else
         sw_address_r <= sw_addr_nxt;
   end

   assign request_pending_flag = pend;
   wire logic unused_ok = ^{gvec, ctrl[0].edge_sense};
endmodule : miv_top
`default_nettype wire

// ### miv_checker.sv
// miv_checker: gating, vector and pending properties at the miv_top ports
// bound into miv_top; one clock domain, reset rst
`timescale 1ns/1ps
`default_nettype none
module miv_checker
   import miv_pkg::*;
#(
   parameter int N = MIV_NSRC
)(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic [MIV_AW-1:0] vector_base_register,
   input wire logic              global_enable,
   input wire logic [2:0]        cpu_priority_threshold,
   input wire logic [N-1:0]      periph_req,
   input wire logic [N-1:0]      pend_write_zero,
   input wire logic              sw_int,
   input wire logic [5:0]        sw_vector,
   input wire logic              accept,
   input wire logic              irq_r,
   input wire miv_grant_t        grant_r,
   input wire logic              sw_valid_r,
   input wire logic [MIV_AW-1:0] sw_address_r,
   input wire logic [N-1:0]      request_pending_flag
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic [4:0] took_r;
   always_ff @(posedge clk) took_r <= grant_r.vector[4:0];
   sequence s_take;
      irq_r && accept;
   endsequence
   sequence s_sw_ok;
      sw_int && sw_vector >= MIV_SW_FIRST;
   endsequence
   a_take_clears: assert property (s_take |=> !irq_r && !request_pending_flag[took_r])
      else $error("taken grant not withdrawn");
   a_irq_level: assert property (irq_r |-> grant_r.level > $past(cpu_priority_threshold))
      else $error("grant level not above threshold");
   a_enable_off: assert property (!global_enable |=> !irq_r)
      else $error("request while disabled");
   a_ipl_block: assert property (cpu_priority_threshold == MIV_IPL_BLOCK |=> !irq_r)
      else $error("request at blocking threshold");
   a_grant_addr: assert property (irq_r |-> grant_r.address ==
      $past(vector_base_register) + {grant_r.vector, 2'b00}) else $error("bad grant address");
   a_grant_mask: assert property (irq_r |-> !grant_r.vector[5])
      else $error("maskable grant in software range");
   a_sw_addr: assert property (s_sw_ok |=> sw_valid_r && sw_address_r ==
      $past(vector_base_register) + {$past(sw_vector), 2'b00}) else $error("bad software vector");
   a_sw_refuse: assert property (!(sw_int && sw_vector >= MIV_SW_FIRST) |=> !sw_valid_r)
      else $error("software vector without cause");
   for (genvar i = 21; i < 32; i++)
   begin : g_slot
      a_pend_set: assert property (periph_req[i] |=> request_pending_flag[i])
         else $error("request did not pend");
      a_pend_clear: assert property (pend_write_zero[i] && !periph_req[i]
         |=> !request_pending_flag[i]) else $error("pending not cleared");
   end
endmodule : miv_checker
bind miv_top miv_checker #(.N(N)) miv_checker_i (
   .clk                    (clk),
   .rst                    (rst),
   .vector_base_register   (vector_base_register),
   .global_enable          (global_enable),
   .cpu_priority_threshold (cpu_priority_threshold),
   .periph_req             (periph_req),
   .pend_write_zero        (pend_write_zero),
   .sw_int                 (sw_int),
   .sw_vector              (sw_vector),
   .accept                 (accept),
   .irq_r                  (irq_r),
   .grant_r                (grant_r),
   .sw_valid_r             (sw_valid_r),
   .sw_address_r           (sw_address_r),
   .request_pending_flag   (request_pending_flag)
);
`default_nettype wire

// ### miv_core_model.sv
// miv_core_model: core side, takes a presented grant after dly cycles
// watches irq_r; drives accept at falling edges
`timescale 1ns/1ps
`default_nettype none
module miv_core_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       irq_r,
   input  wire logic [1:0] dly,
   output var  logic       accept
);
   logic [1:0] wait_r;
   // a grant that vanishes while waiting is simply not taken
   always_ff @(negedge clk or posedge rst)
      if (rst)
      begin
         wait_r <= 2'h0;
         accept <= 1'b0;
      end
      else if (accept || !irq_r)
      begin
         wait_r <= 2'h0;
         accept <= 1'b0;
      end
      else if (wait_r == dly)
         accept <= 1'b1;
      else
         wait_r <= wait_r + 2'h1;
endmodule : miv_core_model
`default_nettype wire

// ### miv_top_tb.sv
// miv_top_tb: self-checking bench for miv_top
// core model answers grants; inputs change at falling edges
`timescale 1ns/1ps
`default_nettype none
module miv_top_tb
   import miv_pkg::*;
;
   localparam int N = MIV_NSRC;
   logic clk = 0, rst = 1, global_enable = 1, sw_int = 0, accept, irq_r, sw_valid_r;
   logic [MIV_AW-1:0] vector_base_register = '0, sw_address_r;
   logic [7:0] source_select_reg_a = '0, source_select_reg_b = '0;
   logic [2:0] cpu_priority_threshold = '0;
   logic [5:0] sw_vector = '0;
   logic [N-1:0] periph_req = '0, pend_write_zero = '0, request_pending_flag;
   logic [1:0] dly = '0;
   logic [28:0] q[$], e;
   miv_ctrl_t [N-1:0] ctrl = '0;
   miv_src_t src = '0;
   miv_grant_t grant_r;
   int n_mismatch = 0, compares = 0, seed = 32'h9f4b5595, i, v, l, t;
   logic [18:0] rs [18] = '{19'h40000, 19'h24000, 19'h10000, 19'h0c000, 19'h03000,
      19'h04800, 19'h00020, 19'h00300, 19'h00040, 19'h00004, 19'h00008, 19'h00010,
      19'h00002, 19'h00001, 19'h00002, 19'h00020, 19'h44000, 19'h07000};
   logic [7:0] ra [18] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h00, 8'h40, 8'h00,
      8'h00, 8'h00, 8'h01, 8'h00, 8'h02, 8'h02, 8'h80, 8'h00, 8'h80};
   // zero means the wrongly selected source must stay silent
   int rv [18] = '{19, 19, 20, 20, 6, 6, 6, 7, 7, 8, 9, 9, 14, 14, 0, 0, 0, 0};
   miv_top #(.N(N)) miv_top_i (
      .clk                    (clk),
      .rst                    (rst),
      .vector_base_register   (vector_base_register),
      .source_select_reg_a    (source_select_reg_a),
      .source_select_reg_b    (source_select_reg_b),
      .global_enable          (global_enable),
      .cpu_priority_threshold (cpu_priority_threshold),
      .ctrl                   (ctrl),
      .periph_req             (periph_req),
      .src                    (src),
      .pend_write_zero        (pend_write_zero),
      .sw_int                 (sw_int),
      .sw_vector              (sw_vector),
      .accept                 (accept),
      .irq_r                  (irq_r),
      .grant_r                (grant_r),
      .sw_valid_r             (sw_valid_r),
      .sw_address_r           (sw_address_r),
      .request_pending_flag   (request_pending_flag)
   );
   miv_core_model miv_core_model_i (
      .clk    (clk),
      .rst    (rst),
      .irq_r  (irq_r),
      .dly    (dly),
      .accept (accept)
   );
   initial forever #12.5 clk = ~clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   // note carries vector, the level software gave that slot, and the fetch address
   task automatic push(input int vn, input int ofs = -1);
      q.push_back({6'(vn), ctrl[5'(vn)].level,
                   vector_base_register + 20'(ofs < 0 ? vn * 4 : ofs)});
   endtask : push
   task automatic pulse(input logic [N-1:0] pr);
      periph_req = pr;
      @(negedge clk) periph_req = '0;
   endtask : pulse
   task automatic drain;
      repeat (60) if (q.size() != 0) @(negedge clk);
      chk(q.size(), 0);
   endtask : drain
   always @(posedge clk)
      if (irq_r === 1'b1 && accept === 1'b1 || sw_valid_r === 1'b1)
      begin
         e = q.size() != 0 ? q.pop_front() : '1;
         if (sw_valid_r === 1'b1)
            chk({e[28:20], sw_address_r}, e);
         else
            chk(grant_r, e);
      end
   initial
   begin
      repeat (2500) @(posedge clk);
      n_mismatch++;
      test_done;
   end
   initial
   begin
      for (i = 0; i < N; i++) ctrl[i].level = 3'h5;
      repeat (8) @(negedge clk);
      rst = 0;
      for (i = 0; i < 18; i++)
      begin
         dly = 2'($random(seed));
         vector_base_register = 20'($random(seed));
         source_select_reg_a = ra[i];
         source_select_reg_b = i == 10 ? 8'hc0 : 8'h80;
         src = rs[i];
         if (rv[i] != 0) push(rv[i]);
         @(negedge clk) src = '0;
         drain;
         chk(request_pending_flag, 0);
      end
      $display("routing test done");
      for (v = 21; v < 32; v++)
      begin
         dly = 2'($random(seed));
         t = v < 26 ? MIV_OFS_TA0 + (v - 21) * 4
                    : v < 29 ? MIV_OFS_TB0 + (v - 26) * 4 : MIV_OFS_LINE0 + (v - 29) * 4;
         push(v, t);
         pulse(32'h1 << v);
         drain;
      end
      $display("slot test done");
      for (i = 0; i < 24; i++)
      begin
         l = $random(seed) & 7;
         t = i == 0 ? 7 : $random(seed) & 7;
         global_enable = i % 5 != 1;
         ctrl[21].level = 3'(l);
         cpu_priority_threshold = 3'(t);
         if (global_enable && l > t) push(21);
         pulse(32'h1 << 21);
         drain;
         repeat (3) @(negedge clk);
         chk(irq_r, 0);
         chk(request_pending_flag[21], !(global_enable && l > t));
         pend_write_zero[21] = 1;
         @(negedge clk) pend_write_zero[21] = 0;
         chk(request_pending_flag[21], 0);
      end
      $display("gating test done");
      global_enable = 1;
      cpu_priority_threshold = 3'h0;
      ctrl[22].level = 3'h3;
      ctrl[25].level = 3'h6;
      push(25);
      push(22);
      pulse(32'h02400000);
      drain;
      // narrow external bus: lines 4 and 5 parked at level zero must only pend
      ctrl[MIV_V_LINE5].level = MIV_LVL_OFF;
      ctrl[MIV_V_S3_L4].level = MIV_LVL_OFF;
      source_select_reg_b = 8'hc0;
      src.line4 = 1'b1;
      src.line5 = 1'b1;
      @(negedge clk) src = '0;
      repeat (3) @(negedge clk);
      chk(irq_r, 0);
      chk(request_pending_flag, (32'h1 << MIV_V_LINE5) | (32'h1 << MIV_V_S3_L4));
      pend_write_zero = (32'h1 << MIV_V_LINE5) | (32'h1 << MIV_V_S3_L4);
      @(negedge clk) pend_write_zero = '0;
      chk(request_pending_flag, 0);
      $display("priority test done");
      for (i = 0; i < 8; i++)
      begin
         global_enable = i[1];
         sw_vector = {i[0], 5'($random(seed))};
         if (i[0]) push(sw_vector);
         sw_int = 1;
         @(negedge clk) sw_int = 0;
         repeat (2) @(negedge clk);
         chk(q.size(), 0);
      end
      $display("software test done");
      test_done;
   end
endmodule : miv_top_tb
`default_nettype wire
